// *** core/standby_command_sequencer.sv ***
/*
  Standby command sequencer: Wishbone registers, instruction store,
  general registers, command engine and memory master port.
  Assumes a memory that answers each request with a one-cycle mem_ack.
*/
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// - Code 0000 stores low byte of reg m; 0001 loads byte into m.
// - Code 0010 stores 16-bit reg m; 0011 loads a word into m.
// - Code 0100 sets, 0101 clears, the selected bit of a memory byte.
// - Code 0110 copies the selected memory bit into carry.
// - Code 0111 does add, subtract, compare or right shift by sub-code.
// - Code 1000 adds signed displacement to pointer when condition holds.
// - Code 1001 pauses for a period set by two immediates.
// - Codes 1010/1011 repeat same entry while memory bit is 1/0.
// - Termination clears the pointer and stops sequencing.
// - Code 1111 sub-code 0010 pulses the transfer controller request.
// - Zero flag shows whether add, subtract or compare gave zero.
// - Carry takes overflow, borrow, shifted-out bit or moved bit.
// - Zero and carry flags are readable in the status register.
// - Selected trigger runs entry 0, then entry at the pointer.
// - After termination the sequencer waits for the next trigger.
// - Writing forced stop halts the sequencer at once.
// - Command clearing the mask bit sets request flag, raises interrupt.
// - Sub-code 0001 interrupts and terminates in the same cycle, keeping both flags.
// - Entry 31 without termination or branch terminates automatically.
module standby_command_sequencer (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] trig_events,
  output seq_pkg::mem_cmd_t mem_cmd,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic xfer_request,
  output logic seq_end_interrupt,
  output logic running_status_bit
);
  import seq_pkg::*;

  typedef struct packed {
    st_t st;
    logic [4:0] ptr;
    logic run;
    logic zf;
    logic cy;
    logic start;
    logic [4:0] tsel;
    logic mask;
    logic flag;
    logic irq;
    logic xfer;
    logic loc;
    logic [7:0] dly;
    mem_cmd_t mem;
    logic ack;
    logic [31:0] dat;
    logic [15:0][15:0] gr;
    logic [31:0][15:0] ins;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [15:0] ins_cur;
  logic [3:0] op;
  logic [3:0] fa;
  logic [3:0] fb;
  logic [3:0] fc;
  logic [15:0] ea;
  logic [15:0] rd;
  logic [7:0] bb;
  logic [31:0] cw;
  logic [31:0] rdat;
  logic done;
  logic adv;
  logic term;
  logic taken;
  logic wb_wr;
  logic [15:0] alu_res;
  logic alu_cy;
  logic alu_zf;

  // ==========================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        m[8*i +: 8] = nw[8*i +: 8];
    return m;
  endfunction

  seq_alu u_alu (
    .a(s_r.gr[fa]),
    .b(s_r.gr[fb]),
    .func(fc),
    .res(alu_res),
    .cy(alu_cy),
    .zf(alu_zf)
  );

  // ==========================================
  // Next state
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.xfer = 1'b0;
    s_nxt.ack = 1'b0;
    ins_cur = s_r.ins[s_r.ptr];
    op = ins_cur[15:12];
    fa = ins_cur[11:8];
    fb = ins_cur[7:4];
    fc = ins_cur[3:0];
    ea = s_r.gr[fa] + {12'h000, fc};
    rd = s_r.loc ? {15'h0000, s_r.mask} << MASK_POS : mem_rdata;
    bb = rd[7:0];
    done = s_r.loc | (s_r.mem.req & mem_ack);
    adv = 1'b0;
    term = 1'b0;
    taken = 1'b0;
    wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & s_r.ack;
    cw = 32'h0000_0000;
    cw[CTRL_START] = s_r.start;
    cw[CTRL_TSEL +: 5] = s_r.tsel;
    cw = merge(cw, wb_dat_i, wb_sel_i);

    // Bus answer one cycle after the request
    rdat = 32'h0000_0000;
    if (wb_adr_i == OFS_CTRL)
      rdat[CTRL_TSEL +: 5] = s_r.tsel;
    if (wb_adr_i == OFS_CTRL)
      rdat[CTRL_START] = s_r.start;
    if (wb_adr_i == OFS_STAT)
      rdat[7:0] = {s_r.cy, s_r.zf, s_r.run, s_r.ptr};
    if (wb_adr_i == OFS_IRQ)
      rdat[1:0] = {s_r.flag, s_r.mask};
    if (wb_adr_i[7:6] == OFS_GEN[7:6])
      rdat[15:0] = s_r.gr[wb_adr_i[5:2]];
    if (wb_adr_i[7] == OFS_INS[7])
      rdat[15:0] = s_r.ins[wb_adr_i[6:2]];
    if (wb_cyc_i && wb_stb_i && !s_r.ack)
    begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = rdat;
    end

    // Software writes first, so sequencer updates win
    if (wb_wr && wb_adr_i == OFS_CTRL)
    begin
      s_nxt.start = cw[CTRL_START];
      s_nxt.tsel = cw[CTRL_TSEL +: 5];
    end
    if (wb_wr && wb_adr_i == OFS_IRQ && wb_sel_i[0])
    begin
      s_nxt.mask = wb_dat_i[IRQ_MASK];
      s_nxt.flag = wb_dat_i[IRQ_FLAG];
    end
    if (wb_wr && wb_adr_i[7:6] == OFS_GEN[7:6])
      s_nxt.gr[wb_adr_i[5:2]] = 16'(merge({16'h0000,
        s_r.gr[wb_adr_i[5:2]]}, wb_dat_i, wb_sel_i));
    if (wb_wr && wb_adr_i[7] == OFS_INS[7])
      s_nxt.ins[wb_adr_i[6:2]] = 16'(merge({16'h0000,
        s_r.ins[wb_adr_i[6:2]]}, wb_dat_i, wb_sel_i));

    // Command engine
    unique case (s_r.st)
      ST_IDLE:
        if (s_r.start)
          s_nxt.st = ST_TRIG;
      ST_TRIG:
        if (!s_r.start)
          s_nxt.st = ST_IDLE;
        else if (trig_events[s_r.tsel])
        begin
          s_nxt.st = ST_EXEC;
          s_nxt.ptr = 5'h00;
          s_nxt.run = 1'b1;
        end
      ST_EXEC:
        unique case (op)
          OP_STB, OP_LDB, OP_STW, OP_LDW, OP_SETB, OP_CLRB, OP_MOVC,
          OP_WT1, OP_WT0:
          begin
            s_nxt.loc = (ea == MASK_ADDR);
            s_nxt.mem.req = (ea != MASK_ADDR);
            s_nxt.mem.we = (op == OP_STB) || (op == OP_STW);
            s_nxt.mem.word = (op == OP_STW) || (op == OP_LDW);
            s_nxt.mem.addr = ea;
            s_nxt.mem.wdata = (op == OP_STW) ? s_r.gr[fb] :
              {8'h00, s_r.gr[fb][7:0]};
            s_nxt.st = ST_MEM;
          end
          OP_WORD:
          begin
            if (fc == SUB_ADD || fc == SUB_SUB || fc == SUB_SHR)
              s_nxt.gr[fa] = alu_res;
            if (fc <= SUB_SHR)
              s_nxt.cy = alu_cy;
            if (fc <= SUB_CMP)
              s_nxt.zf = alu_zf;
            adv = 1'b1;
          end
          OP_BR:
          begin
            if (fc == 4'h0)
              taken = s_r.cy;
            else if (fc == 4'h1)
              taken = !s_r.cy;
            else if (fc == 4'h2)
              taken = s_r.zf;
            else if (fc == 4'h3)
              taken = !s_r.zf;
            // Not taken at entry 31 wraps to 0, no automatic end
            if (taken)
              s_nxt.ptr = s_r.ptr + ins_cur[8:4];
            else
              s_nxt.ptr = s_r.ptr + 5'h01;
          end
          OP_WAIT:
          begin
            s_nxt.dly = {fa, fc};
            s_nxt.st = ST_DELAY;
          end
          OP_SYS:
            if (ins_cur[11:0] == SYS_TERM)
              term = 1'b1;
            else if (ins_cur[11:0] == SYS_IRQ)
            begin
              s_nxt.flag = 1'b1;
              s_nxt.mask = 1'b0;
              term = 1'b1;
            end
            else
            begin
              s_nxt.xfer = (ins_cur[11:0] == SYS_XFER);
              adv = 1'b1;
            end
          default:
            adv = 1'b1;
        endcase
      ST_MEM:
        if (done)
        begin
          s_nxt.mem.req = 1'b0;
          s_nxt.loc = 1'b0;
          if (s_r.mem.we)
          begin
            // Only the mask byte is local; clearing the set bit raises the request flag
            if (s_r.loc && s_r.mask && !s_r.mem.wdata[MASK_POS])
              s_nxt.flag = 1'b1;
            if (s_r.loc)
              s_nxt.mask = s_r.mem.wdata[MASK_POS];
            adv = 1'b1;
          end
          else if (op == OP_LDB)
          begin
            s_nxt.gr[fb] = {8'h00, bb};
            adv = 1'b1;
          end
          else if (op == OP_LDW)
          begin
            s_nxt.gr[fb] = rd;
            adv = 1'b1;
          end
          else if (op == OP_SETB || op == OP_CLRB)
          begin
            bb[fb[2:0]] = (op == OP_SETB);
            s_nxt.mem.wdata = {8'h00, bb};
            s_nxt.mem.we = 1'b1;
            s_nxt.mem.req = !s_r.loc;
            s_nxt.loc = s_r.loc;
          end
          else if (op == OP_MOVC)
          begin
            s_nxt.cy = bb[fb[2:0]];
            adv = 1'b1;
          end
          else if (bb[fb[2:0]] == (op == OP_WT1))
            s_nxt.st = ST_EXEC;
          else
            adv = 1'b1;
        end
      ST_DELAY:
        if (s_r.dly == 8'h00)
          adv = 1'b1;
        else
          s_nxt.dly = s_r.dly - 8'h01;
      default:
        s_nxt.st = ST_IDLE;
    endcase

    if (adv && s_r.ptr == LAST_PTR)
      term = 1'b1;
    else if (adv)
    begin
      s_nxt.ptr = s_r.ptr + 5'h01;
      s_nxt.st = ST_EXEC;
    end
    if (term)
    begin
      s_nxt.ptr = 5'h00;
      s_nxt.run = 1'b0;
      s_nxt.st = ST_TRIG;
    end

    // Forced stop also wipes the control register
    if (wb_wr && wb_adr_i == OFS_CTRL && cw[CTRL_STOP])
    begin
      s_nxt.st = ST_IDLE;
      s_nxt.ptr = 5'h00;
      s_nxt.run = 1'b0;
      s_nxt.start = 1'b0;
      s_nxt.tsel = 5'h00;
      s_nxt.mem.req = 1'b0;
      s_nxt.loc = 1'b0;
      s_nxt.xfer = 1'b0;
    end
    s_nxt.irq = s_nxt.flag & !s_nxt.mask;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      s_r <= '0;
    else if (clk_en)
      s_r <= s_nxt;
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign mem_cmd = s_r.mem;
  assign xfer_request = s_r.xfer;
  assign seq_end_interrupt = s_r.irq;
  assign running_status_bit = s_r.run;

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn || !clk_en);

  sequence s_exec(logic [15:0] code);
    s_r.st == ST_EXEC && ins_cur == code;
  endsequence

  sequence s_back_to_wait;
    s_r.st == ST_TRIG && s_r.ptr == 5'h00 && !s_r.run;
  endsequence

  sequence s_stop_write;
    wb_wr && wb_adr_i == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_STOP];
  endsequence

  a_stop_halts: assert property (s_stop_write |=>
    s_r.st == ST_IDLE && !s_r.run && !s_r.start && !mem_cmd.req)
    else $error("forced stop did not halt");

  a_term_waits: assert property (s_exec(16'hf000) |=>
    s_back_to_wait)
    else $error("termination did not return to trigger wait");

  a_xfer_pulse: assert property (s_exec(16'hf002) |=>
    xfer_request ##1 !xfer_request)
    else $error("transfer request is not a single pulse");

  a_irq_term: assert property (s_exec(16'hf001) |=>
    s_back_to_wait ##0 (seq_end_interrupt && s_r.zf == $past(s_r.zf)
    && s_r.cy == $past(s_r.cy)))
    else $error("interrupt plus termination misbehaved");

  a_trigger_entry0: assert property (s_r.st == ST_TRIG && s_r.start
    && trig_events[s_r.tsel] && !wb_wr |=> s_r.st == ST_EXEC
    && s_r.ptr == 5'h00 && running_status_bit)
    else $error("trigger did not start at entry zero");

  a_word_zero: assert property (s_r.st == ST_EXEC && op == OP_WORD
    && fc <= SUB_CMP |=> s_r.zf == ($past(alu_res) == 16'h0000))
    else $error("zero flag wrong after word operation");

  a_shift_carry: assert property (s_r.st == ST_EXEC && op == OP_WORD
    && fc == SUB_SHR |=> s_r.cy == $past(s_r.gr[fa][0]))
    else $error("shift did not move bit 0 into carry");

  a_branch_target: assert property (s_r.st == ST_EXEC && op == OP_BR
    && ((fc == 4'h0 && s_r.cy) || (fc == 4'h2 && s_r.zf)) && !wb_wr
    |=> s_r.ptr == 5'($past(s_r.ptr) + $past(ins_cur[8:4])))
    else $error("taken branch went to the wrong entry");

  a_auto_term: assert property (s_r.st == ST_EXEC && op == OP_WORD
    && s_r.ptr == LAST_PTR && !wb_wr |=> s_back_to_wait)
    else $error("entry 31 did not terminate");

  a_word_advance: assert property (s_r.st == ST_EXEC && op == OP_WORD
    && s_r.ptr != LAST_PTR && !wb_wr
    |=> s_r.ptr == 5'($past(s_r.ptr) + 5'h01))
    else $error("pointer did not advance by one");

  a_wait_hold: assert property (s_r.st == ST_MEM && done
    && (op == OP_WT1 || op == OP_WT0) && !wb_wr
    && bb[fb[2:0]] == (op == OP_WT1)
    |=> s_r.st == ST_EXEC && s_r.ptr == $past(s_r.ptr))
    else $error("conditional wait did not hold");

  a_mask_irq: assert property (s_r.st == ST_MEM && s_r.loc
    && s_r.mem.we && s_r.mask && !s_r.mem.wdata[MASK_POS]
    |=> seq_end_interrupt && s_r.flag && !s_r.mask)
    else $error("clearing the mask did not raise the interrupt");

  a_delay_length: assert property (s_exec(16'h9002) && !wb_wr
    |=> (s_r.st == ST_DELAY)[*3] ##1 s_r.st != ST_DELAY)
    else $error("wait period length wrong");

endmodule

// *** shared/seq_pkg.sv ***
/*
  Constants and types shared by the standby command sequencer files.
  Assumes a 32-bit classic Wishbone register bus and a 20 MHz sys_clk.
*/
package seq_pkg;

  // ==========================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ = 8'h08;
  localparam logic [7:0] OFS_GEN = 8'h40;
  localparam logic [7:0] OFS_INS = 8'h80;

  // ==========================================
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_TSEL = 4;
  localparam int STAT_RUN = 5;
  localparam int STAT_ZF = 6;
  localparam int STAT_CY = 7;
  localparam int IRQ_MASK = 0;
  localparam int IRQ_FLAG = 1;

  // ==========================================
  // Interrupt mask byte as seen by commands
  localparam logic [15:0] MASK_ADDR = 16'hffe6;
  localparam int MASK_POS = 0;

  // ==========================================
  // Command codes and sub-codes
  localparam logic [3:0] OP_STB = 4'h0;
  localparam logic [3:0] OP_LDB = 4'h1;
  localparam logic [3:0] OP_STW = 4'h2;
  localparam logic [3:0] OP_LDW = 4'h3;
  localparam logic [3:0] OP_SETB = 4'h4;
  localparam logic [3:0] OP_CLRB = 4'h5;
  localparam logic [3:0] OP_MOVC = 4'h6;
  localparam logic [3:0] OP_WORD = 4'h7;
  localparam logic [3:0] OP_BR = 4'h8;
  localparam logic [3:0] OP_WAIT = 4'h9;
  localparam logic [3:0] OP_WT1 = 4'ha;
  localparam logic [3:0] OP_WT0 = 4'hb;
  localparam logic [3:0] OP_SYS = 4'hf;
  localparam logic [3:0] SUB_ADD = 4'h0;
  localparam logic [3:0] SUB_SUB = 4'h1;
  localparam logic [3:0] SUB_CMP = 4'h2;
  localparam logic [3:0] SUB_SHR = 4'h3;
  localparam logic [11:0] SYS_TERM = 12'h000;
  localparam logic [11:0] SYS_IRQ = 12'h001;
  localparam logic [11:0] SYS_XFER = 12'h002;
  localparam logic [4:0] LAST_PTR = 5'h1f;

  // ==========================================
  // Sequencer states and memory command
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TRIG = 3'b001,
    ST_EXEC = 3'b010,
    ST_MEM = 3'b011,
    ST_DELAY = 3'b100
  } st_t;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_cmd_t;

endpackage

// *** core/seq_alu.sv ***
/*
  Word arithmetic unit of the sequencer: add, subtract, compare, shift.
  Assumes the caller picks which results to store.
*/
`timescale 1ns/10ps
module seq_alu (
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic [3:0] func,
  output logic [15:0] res,
  output logic cy,
  output logic zf
);
  import seq_pkg::*;

  logic [16:0] wide;

  // ==========================================
  // Datapath
  always_comb
  begin
    if (func == SUB_ADD)
      wide = {1'b0, a} + {1'b0, b};
    else if (func == SUB_SHR)
      wide = {a[0], 1'b0, a[15:1]};
    else
      wide = {1'b0, a} - {1'b0, b};
    res = wide[15:0];
    cy = wide[16];
    zf = (wide[15:0] == 16'h0000);
  end

endmodule

// *** dv/seq_mem_model.sv ***
/*
  Memory partner of the sequencer: 256-byte store, little-endian words.
  Assumes mem_cmd held to mem_ack; answers after 0 to 2 stall cycles.
*/
`timescale 1ns/10ps
module seq_mem_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire seq_pkg::mem_cmd_t mem_cmd,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  import seq_pkg::*;

  // ==========================================
  // Store and answer logic
  logic [7:0] mem [256];
  logic [7:0] a0;
  logic [7:0] a1;
  int delay;

  // Known pattern so the bench can predict untouched bytes
  initial
  begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  end

  assign a0 = mem_cmd.addr[7:0];
  assign a1 = a0 + 8'h1;

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0;
      delay <= 0;
    end
    else
    begin
      mem_ack <= 1'b0;
      // Idle data keeps toggling so stale values never look valid
      mem_rdata <= ~mem_rdata;
      if (mem_cmd.req && !mem_ack)
      begin
        if (delay == 0)
        begin
          mem_ack <= 1'b1;
          delay <= $urandom % 3;
          if (mem_cmd.we)
          begin
            mem[a0] <= mem_cmd.wdata[7:0];
            if (mem_cmd.word)
              mem[a1] <= mem_cmd.wdata[15:8];
          end
          else
            mem_rdata <= {mem_cmd.word ? mem[a1] : ~mem[a0], mem[a0]};
        end
        else
          delay <= delay - 1;
      end
    end
  end
endmodule

// *** dv/tb.sv ***
/*
  Self-checking bench of the standby command sequencer.
  Assumes the seq_pkg register map and the memory partner model.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import seq_pkg::*;

  // ==========================================
  // Signals
  logic sys_clk, rstn, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, trig_events, q;
  logic mem_ack, xfer_request, seq_end_interrupt, running_status_bit;
  mem_cmd_t mem_cmd;
  logic [15:0] mem_rdata;
  logic [15:0] gr [16];
  logic [15:0] pg [16];
  logic [16:0] sum;
  logic [7:0] b2, st;
  int mismatches, num_checks, xfers, tsel, s, seed_v;

  standby_command_sequencer uut (.sys_clk(sys_clk), .rstn(rstn),
    .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trig_events(trig_events), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .xfer_request(xfer_request),
    .seq_end_interrupt(seq_end_interrupt),
    .running_status_bit(running_status_bit));
  seq_mem_model mem_m (.sys_clk(sys_clk), .rstn(rstn), .mem_cmd(mem_cmd),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (xfer_request === 1'b1) xfers++;

  // ==========================================
  // Tasks
  task report_and_stop;
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One classic cycle; result lands in q
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task wait_run(input logic lvl);
    int n;
    n = 0;
    while (running_status_bit !== lvl && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 400)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // Event dropped as soon as the round starts, so it cannot retrigger
  task round(input logic to_end);
    trig_events <= 32'h1 << tsel;
    wait_run(1'b1);
    trig_events <= $urandom & ~(32'h1 << tsel);
    if (to_end)
      wait_run(1'b0);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    {mismatches, num_checks, xfers} = '0;
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    clk_en = 1'b1;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    trig_events = 32'h0;
    seed_v = $urandom(32'h34a44e62);
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    tsel = $urandom % 32;
    s = $urandom % 8;
    foreach (gr[i]) gr[i] = $urandom;
    gr[1] = 16'h0010 + 16'(($urandom % 60) * 2);
    gr[10] = MASK_ADDR;
    pg = '{16'h2120, 16'h1131, 16'h7450, 16'h7661, 16'h7703, 16'h4102,
      16'h6102, 16'h8020, 16'h7880, 16'hf002, 16'h5102, 16'h3192,
      16'h01d3, 16'h9002, 16'h5a00, 16'hf000};
    pg[5][6:4] = 3'(s);
    pg[6][6:4] = 3'(s);
    pg[10][6:4] = 3'(s);
    foreach (gr[i]) wb(1'b1, OFS_GEN + 8'(4 * i), {16'h0, gr[i]});
    foreach (pg[i]) wb(1'b1, OFS_INS + 8'(4 * i), {16'h0, pg[i]});
    wb(1'b1, OFS_IRQ, 32'h3);
    wb(1'b1, OFS_CTRL, 32'(tsel << 4) | 32'h1);
    wb(1'b0, OFS_CTRL, 32'h0);
    `CHK(q, 32'(tsel << 4) | 32'h1)
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK(q, 32'h0)
    round(1'b1);
    // Predicted results of the first round
    b2 = (gr[1][7:0] + 8'h2) ^ 8'h5a;
    b2 = b2 & ~(8'h1 << s);
    sum = gr[4] + gr[5];
    gr[4] = sum[15:0];
    gr[6] = 16'h0;
    gr[7] = gr[7] >> 1;
    gr[9] = {(gr[1][7:0] + 8'h3) ^ 8'h5a, b2};
    for (int i = 0; i < 16; i++)
    begin
      wb(1'b0, OFS_GEN + 8'(4 * i), 32'h0);
      if (i == 3)
        `CHK(q[7:0], gr[2][15:8])
      else
        `CHK(q, {16'h0, gr[i]})
    end
    `CHK(mem_m.mem[gr[1][7:0]], gr[2][7:0])
    `CHK(mem_m.mem[8'(gr[1][7:0] + 8'h1)], gr[2][15:8])
    `CHK(mem_m.mem[8'(gr[1][7:0] + 8'h2)], b2)
    `CHK(mem_m.mem[8'(gr[1][7:0] + 8'h3)], gr[13][7:0])
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK(q[7:0], 8'hc0)
    `CHK(xfers, 1)
    `CHK(seq_end_interrupt, 1'b1)
    wb(1'b0, OFS_IRQ, 32'h0);
    `CHK(q[1:0], 2'b10)
    // Second round: branch back to entry 31, then automatic end
    wb(1'b1, OFS_IRQ, 32'h3);
    wb(1'b1, OFS_INS, 32'h8ff0);
    wb(1'b1, OFS_INS + 8'h7c, 32'h7bc0);
    round(1'b1);
    sum = gr[11] + gr[12];
    wb(1'b0, OFS_GEN + 8'h2c, 32'h0);
    `CHK(q, {16'h0, sum[15:0]})
    st = {sum[16], sum[15:0] == 16'h0, 6'h0};
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK(q[7:0], st)
    `CHK(seq_end_interrupt, 1'b0)
    // Third round: interrupt plus termination keeps both flags
    wb(1'b1, OFS_INS, 32'hf001);
    round(1'b1);
    `CHK(seq_end_interrupt, 1'b1)
    wb(1'b0, OFS_STAT, 32'h0);
    `CHK(q[7:0], st)
    // Fourth round: wait on a cleared bit, then forced stop
    wb(1'b1, OFS_INS, 32'hb102 | 32'(s << 4));
    // Frozen clock enable must hide a pending trigger
    clk_en <= 1'b0;
    trig_events <= 32'h1 << tsel;
    repeat (5) @(posedge sys_clk);
    `CHK(running_status_bit, 1'b0)
    clk_en <= 1'b1;
    round(1'b0);
    repeat (20) @(posedge sys_clk);
    `CHK(running_status_bit, 1'b1)
    wb(1'b1, OFS_CTRL, 32'h2);
    @(posedge sys_clk);
    `CHK(running_status_bit, 1'b0)
    wb(1'b0, OFS_CTRL, 32'h0);
    `CHK(q, 32'h0)
    report_and_stop();
  end
endmodule
